/* rtl/gpiop_pkg.sv */
// package of constants for the general purpose io port block
package gpiop_pkg;
   localparam int PORT_W = 6;
   localparam int DATA_W = 8;
   localparam logic [4:0] ADDR_STATUS = 5'h03;
   localparam logic [4:0] ADDR_PORT_A = 5'h06;
   localparam logic [4:0] ADDR_PORT_B = 5'h07;
   localparam logic [2:0] DIR_SEL_A = 3'h6;
   localparam logic [2:0] DIR_SEL_B = 3'h7;
   localparam logic [PORT_W-1:0] DIR_RESET = 6'h3f;
   localparam logic [DATA_W-1:0] OPTION_RESET = 8'hff;
   localparam int OPT_WAKE_BIT = 7;
   localparam int OPT_PULL_BIT = 6;
   localparam int OPT_TMRCS_BIT = 5;
   localparam int STATUS_WAKE_BIT = 7;
   localparam int INPUT_ONLY_BIT = 3;
   localparam int TIMER_PIN_BIT = 2;
   localparam logic [PORT_W-1:0] SHARED_MASK = 6'h1b;
   localparam logic [PORT_W-1:0] ZERO_PORT = 6'h00;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
endpackage : gpiop_pkg

/* rtl/gpiop_sync.sv */
// two flip-flop synchroniser for the pin inputs
module gpiop_sync
   import gpiop_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [PORT_W-1:0] d,
   output logic [PORT_W-1:0] q
);
   // first stage, read only by the second
   logic [PORT_W-1:0] meta_r;
   // two stage capture
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= ZERO_PORT;
         q <= ZERO_PORT;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : gpiop_sync

/* rtl/gpiop_top.sv */
// general purpose io port: two 6-bit ports, direction, pull-ups and wake-on-change
// Overview of operation
// R01: port reads return live pin levels
// R02: upper two data bits read zero
// R03: pin 3 is input only
// R04: alternate function pins read zero
// R05: shared pull-up and wake on pins 0,1,3,4
// R06: clear-input mode forces pull-up, no wake
// R07: direction load copies working register
// R08: direction 1 floats, 0 drives latch
// R09: timer clock select overrides pin direction
// R10: direction write-only, all ones on reset
// R11: latches hold; inputs not latched
// R12: other pins individually direction programmable
// R13: status bit 7 marks wake reset
// R14: data latches kept over resets, option ones
// R15: bit set/clear rewrites whole port latch
// R16: writes at cycle end, reads at start
// R17: software separates port write and read
// R18: option bit 7 disables wake when 1
// R19: option bit 6 disables pull-ups when 1
module gpiop_top
   import gpiop_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cyc_en,
   input wire logic [4:0] file_addr,
   input wire logic rd_en,
   input wire logic wr_en,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic bit_set_instr,
   input wire logic bit_clear_instr,
   input wire logic [2:0] bit_sel,
   input wire logic direction_load_instr,
   input wire logic [2:0] dir_sel,
   input wire logic [DATA_W-1:0] work_data,
   input wire logic option_load,
   input wire logic wake_reset_cause,
   input wire logic master_clear_input,
   input wire logic [PORT_W-1:0] alt_fn_a,
   input wire logic [PORT_W-1:0] alt_fn_b,
   input wire logic [PORT_W-1:0] pin_a_in,
   input wire logic [PORT_W-1:0] pin_b_in,
   output logic [PORT_W-1:0] pin_a_out,
   output logic [PORT_W-1:0] pin_a_oe,
   output logic [PORT_W-1:0] pin_b_out,
   output logic [PORT_W-1:0] pin_b_oe,
   output logic [PORT_W-1:0] pullup_en,
   output logic [DATA_W-1:0] rd_data,
   output logic wake_change_reset_flag,
   output logic wake_event,
   output logic [DATA_W-1:0] option_out
);
   // synchronised pin levels
   logic [PORT_W-1:0] pin_a_s;
   logic [PORT_W-1:0] pin_b_s;
   // output latches, direction and option
   logic [PORT_W-1:0] latch_a_r;
   logic [PORT_W-1:0] latch_b_r;
   logic [PORT_W-1:0] dir_a_r;
   logic [PORT_W-1:0] dir_b_r;
   logic [DATA_W-1:0] option_r;
   // read data register and wake flag
   logic [DATA_W-1:0] rd_data_r;
   logic wake_flag_r;
   // wake reference snapshot
   logic [PORT_W-1:0] wake_ref_r;
   logic [PORT_W-1:0] wake_mask;
   logic [PORT_W-1:0] dir_a_eff;
   logic rmw;

   // pad port value to a byte with zero upper bits
   function automatic logic [DATA_W-1:0] pad_port(input logic [PORT_W-1:0] v);
      pad_port = {2'b00, v};
   endfunction : pad_port

   // live port view with alternate pins read as zero
   function automatic logic [PORT_W-1:0] port_view(input logic [PORT_W-1:0] pins,
                                                   input logic [PORT_W-1:0] alt);
      port_view = pins & ~alt;
   endfunction : port_view

   // read-modify-write of a single bit on the pin view
   function automatic logic [PORT_W-1:0] rmw_value(input logic [PORT_W-1:0] pins,
                                                   input logic [2:0] sel,
                                                   input logic set);
      logic [PORT_W-1:0] v;
      v = pins;
      if (sel < 3'(PORT_W)) begin
         v[sel] = set;
      end
      rmw_value = v;
   endfunction : rmw_value

   gpiop_sync u_sync_a (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .d(pin_a_in),
      .q(pin_a_s)
   );

   gpiop_sync u_sync_b (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .d(pin_b_in),
      .q(pin_b_s)
   );

   assign rmw = bit_set_instr | bit_clear_instr;

   // output latch update at cycle end
   // R11 latch holds value
   // R14 latch untouched by reset
   always_ff @(posedge ref_clk) begin
      if (cyc_en) begin
         // R15 whole port rewritten
         if (rmw && file_addr == ADDR_PORT_A) begin
            latch_a_r <= rmw_value(port_view(pin_a_s, alt_fn_a), bit_sel, bit_set_instr);
         // R16 write at cycle end
         end else if (wr_en && file_addr == ADDR_PORT_A) begin
            latch_a_r <= wr_data[PORT_W-1:0];
         end
         if (rmw && file_addr == ADDR_PORT_B) begin
            latch_b_r <= rmw_value(port_view(pin_b_s, alt_fn_b), bit_sel, bit_set_instr);
         end else if (wr_en && file_addr == ADDR_PORT_B) begin
            latch_b_r <= wr_data[PORT_W-1:0];
         end
      end
   end

   // direction registers, write-only
   always_ff @(posedge ref_clk or negedge reset_n) begin
      // R10 all inputs on reset
      if (!reset_n) begin
         dir_a_r <= DIR_RESET;
         dir_b_r <= DIR_RESET;
      end else if (cyc_en && direction_load_instr) begin
         // R07 copy working register
         // R12 per pin direction
         if (dir_sel == DIR_SEL_A) begin
            dir_a_r <= work_data[PORT_W-1:0];
         end else if (dir_sel == DIR_SEL_B) begin
            dir_b_r <= work_data[PORT_W-1:0];
         end
      end
   end

   // option register
   always_ff @(posedge ref_clk or negedge reset_n) begin
      // R14 option resets to ones
      if (!reset_n) begin
         option_r <= OPTION_RESET;
      end else if (cyc_en && option_load) begin
         option_r <= work_data;
      end
   end

   // effective direction for the first port
   always_comb begin
      dir_a_eff = dir_a_r;
      // R09 timer source forces input
      if (option_r[OPT_TMRCS_BIT]) begin
         dir_a_eff[TIMER_PIN_BIT] = 1'b1;
      end
      // R03 pin 3 never driven
      dir_a_eff[INPUT_ONLY_BIT] = 1'b1;
   end

   // R08 drivers from latch when direction 0
   assign pin_a_oe = ~dir_a_eff;
   assign pin_a_out = latch_a_r & ~dir_a_eff;
   assign pin_b_oe = ~dir_b_r;
   assign pin_b_out = latch_b_r & ~dir_b_r;

   // shared pull-ups
   always_comb begin
      // R05 one shared pull-up control
      // R19 bit 6 low enables
      pullup_en = option_r[OPT_PULL_BIT] ? ZERO_PORT : SHARED_MASK;
      // R06 clear input forces pull-up
      if (master_clear_input) begin
         pullup_en[INPUT_ONLY_BIT] = 1'b1;
      end
   end

   // wake-on-change pin set
   always_comb begin
      // R18 bit 7 low enables wake
      wake_mask = option_r[OPT_WAKE_BIT] ? ZERO_PORT : SHARED_MASK;
      // R06 no wake on clear pin
      if (master_clear_input) begin
         wake_mask[INPUT_ONLY_BIT] = 1'b0;
      end
   end

   // snapshot of pins taken at each first port read
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wake_ref_r <= ZERO_PORT;
      end else if (cyc_en && rd_en && file_addr == ADDR_PORT_A) begin
         wake_ref_r <= pin_a_s;
      end
   end

   // change on an enabled pin against the last read
   assign wake_event = |((pin_a_s ^ wake_ref_r) & wake_mask);

   // wake reset flag, captured after reset release
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wake_flag_r <= 1'b0;
      end else if (wake_reset_cause) begin
         // R13 wake cause sets flag
         wake_flag_r <= 1'b1;
      end
   end

   assign wake_change_reset_flag = wake_flag_r;
   assign option_out = option_r;

   // read data sampled at cycle start
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data_r <= ZERO_BYTE;
      end else if (cyc_en && rd_en) begin
         // R16 sample at read
         case (file_addr)
            // R01 live pins
            // R02 upper bits zero
            // R04 alternate pins zero
            ADDR_PORT_A: rd_data_r <= pad_port(port_view(pin_a_s, alt_fn_a));
            ADDR_PORT_B: rd_data_r <= pad_port(port_view(pin_b_s, alt_fn_b));
            ADDR_STATUS: rd_data_r <= {wake_flag_r, 7'h00};
            default: rd_data_r <= ZERO_BYTE;
         endcase
      end
   end

   assign rd_data = rd_data_r;

   // R01 read follows pin
   AST_READ_PINS: assert property (@(posedge ref_clk) disable iff (!reset_n) // R01
      (cyc_en && rd_en && file_addr == ADDR_PORT_A && alt_fn_a == ZERO_PORT)
      |=> rd_data[PORT_W-1:0] == $past(pin_a_s))
      else $error("port read not pin level");

   // R02 upper bits zero
   AST_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n) // R02
      $past(cyc_en && rd_en && (file_addr == ADDR_PORT_A || file_addr == ADDR_PORT_B))
      |-> rd_data[DATA_W-1:PORT_W] == 2'b00)
      else $error("upper port bits not zero");

   // R03 input-only pin
   AST_INPUT_ONLY: assert property (@(posedge ref_clk) disable iff (!reset_n) // R03
      !pin_a_oe[INPUT_ONLY_BIT])
      else $error("input-only pin driven");

   // R04 alternate reads zero
   AST_ALT_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n) // R04
      (cyc_en && rd_en && file_addr == ADDR_PORT_B)
      |=> (rd_data[PORT_W-1:0] & $past(alt_fn_b)) == ZERO_PORT)
      else $error("alternate pin read nonzero");

   // R07 direction load then hold
   sequence s_dir_load;
      cyc_en && direction_load_instr && dir_sel == DIR_SEL_B;
   endsequence
   AST_DIR_LOAD: assert property (@(posedge ref_clk) disable iff (!reset_n) // R07
      s_dir_load ##1 !(cyc_en && direction_load_instr) |-> pin_b_oe == ~$past(work_data[PORT_W-1:0], 1))
      else $error("direction not loaded");

   // R09 timer source overrides
   AST_TMR_OVERRIDE: assert property (@(posedge ref_clk) disable iff (!reset_n) // R09
      option_r[OPT_TMRCS_BIT] |-> !pin_a_oe[TIMER_PIN_BIT])
      else $error("timer pin driven while external clock");

   // R15 rmw writes pin view
   AST_RMW: assert property (@(posedge ref_clk) disable iff (!reset_n) // R15
      (cyc_en && bit_set_instr && !bit_clear_instr && file_addr == ADDR_PORT_A && bit_sel == 3'h5)
      |=> latch_a_r == ($past(port_view(pin_a_s, alt_fn_a)) | 6'h20))
      else $error("bit set did not rewrite port");

   // R06 clear pin wake masked and pulled up
   AST_MASTER_CLEAR_INPUT: assert property (@(posedge ref_clk) disable iff (!reset_n) // R06
      master_clear_input |-> pullup_en[INPUT_ONLY_BIT] && !wake_mask[INPUT_ONLY_BIT])
      else $error("clear pin pull-up or wake wrong");

   // R19 pull-up disable
   AST_PULL_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n) // R19
      (option_r[OPT_PULL_BIT] && !master_clear_input) |-> pullup_en == ZERO_PORT)
      else $error("pull-ups on while disabled");

   // R18 wake disable
   AST_WAKE_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n) // R18
      option_r[OPT_WAKE_BIT] |-> !wake_event)
      else $error("wake event while disabled");
endmodule : gpiop_top

/* tb/gpiop_pin_model.sv */
// pin-side model: outside drivers, weak pull-ups and floating pins
module gpiop_pin_model
   import gpiop_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [PORT_W-1:0] pin_a_out,
   input wire logic [PORT_W-1:0] pin_a_oe,
   input wire logic [PORT_W-1:0] pin_b_out,
   input wire logic [PORT_W-1:0] pin_b_oe,
   input wire logic [PORT_W-1:0] pullup_en,
   input wire logic [PORT_W-1:0] ext_a_en,
   input wire logic [PORT_W-1:0] ext_a,
   input wire logic [PORT_W-1:0] ext_b_en,
   input wire logic [PORT_W-1:0] ext_b,
   output logic [PORT_W-1:0] pin_a_in,
   output logic [PORT_W-1:0] pin_b_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [PORT_W-1:0] flt_r = 6'h15; // undriven pins wander each cycle
   always @(posedge ref_clk) begin
      flt_r <= ~flt_r;
   end
   // a strong outside level beats the pin driver
   assign pin_a_in = (ext_a_en & ext_a) | (~ext_a_en & pin_a_oe & pin_a_out) | (~ext_a_en & ~pin_a_oe & (pullup_en | flt_r));
   assign pin_b_in = (ext_b_en & ext_b) | (~ext_b_en & pin_b_oe & pin_b_out) | (~ext_b_en & ~pin_b_oe & flt_r);
endmodule : gpiop_pin_model

/* tb/tb_top.sv */
// self-checking bench for the io port block
module tb_top
   import gpiop_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk, reset_n, cyc_en, rd_en, wr_en, bit_set_instr, bit_clear_instr;
   logic direction_load_instr, option_load, wake_reset_cause, master_clear_input;
   logic wake_change_reset_flag, wake_event;
   logic [4:0] file_addr;
   logic [2:0] bit_sel, dir_sel;
   logic [7:0] wr_data, work_data, rd_data, option_out;
   logic [5:0] alt_fn_a, alt_fn_b, pin_a_in, pin_b_in, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, pullup_en;
   logic [5:0] ext_a_en, ext_a, ext_b_en, ext_b;
   int bad_count, checks_done;
   // port, direction, latch, outside enable, outside level, expected read
   typedef struct {logic pb; logic [5:0] dir, lat, een, ev; logic [7:0] exp;} gpiop_row_t;
   gpiop_row_t rows [5] = '{'{1'b0, 6'h00, 6'h2a, 6'h08, 6'h00, 8'h22}, '{1'b0, 6'h3f, 6'h15, 6'h3f, 6'h2d, 8'h2d},
      '{1'b0, 6'h00, 6'h3f, 6'h09, 6'h00, 8'h36}, '{1'b1, 6'h00, 6'h15, 6'h00, 6'h00, 8'h15},
      '{1'b1, 6'h30, 6'h0f, 6'h30, 6'h20, 8'h2f}};
   gpiop_top gpiop_top_i (.*);
   gpiop_pin_model gpiop_pin_model_i (.*);
   initial begin
      ref_clk = 0;
      forever #25 ref_clk = ~ref_clk;
   end
   task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task idle(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask : idle
   // one instruction cycle, strobes dropped after the taking edge
   task go;
      cyc_en = 1;
      @(posedge ref_clk);
      #2;
      {cyc_en, rd_en, wr_en, bit_set_instr, bit_clear_instr, direction_load_instr, option_load} = '0;
      idle(1);
   endtask : go
   task wr(input logic [4:0] a, input logic [7:0] d);
      file_addr = a;
      wr_data = d;
      wr_en = 1;
      go;
   endtask : wr
   task rd(input logic [4:0] a, input logic [7:0] e);
      file_addr = a;
      rd_en = 1;
      go;
      chk("rd_data", e, rd_data);
   endtask : rd
   task dir(input logic [2:0] s, input logic [5:0] d);
      dir_sel = s;
      work_data = {2'h0, d};
      direction_load_instr = 1;
      go;
   endtask : dir
   task opt(input logic [7:0] d);
      work_data = d;
      option_load = 1;
      go;
   endtask : opt
   task rmw(input logic s, input logic [2:0] b);
      file_addr = ADDR_PORT_A;
      bit_sel = b;
      bit_set_instr = s;
      bit_clear_instr = !s;
      go;
   endtask : rmw
   task rst(input logic c);
      wake_reset_cause = c;
      reset_n = 0;
      repeat (4) @(posedge ref_clk);
      #2;
      reset_n = 1;
      idle(2);
   endtask : rst
   task results;
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results
   // watchdog against a hang
   initial begin
      #1000000;
      bad_count++;
      results;
   end
   initial begin
      {cyc_en, rd_en, wr_en, bit_set_instr, bit_clear_instr, direction_load_instr, option_load} = '0;
      {file_addr, bit_sel, dir_sel, wr_data, work_data, master_clear_input} = '0;
      {alt_fn_a, alt_fn_b, ext_a_en, ext_a, ext_b_en, ext_b} = '0;
      rst(0);
      chk("oe_a", 8'h00, {2'h0, pin_a_oe});
      chk("option", OPTION_RESET, option_out);
      chk("flag", 8'h00, {7'h0, wake_change_reset_flag});
      opt(8'hdf);
      foreach (rows[i]) begin
         dir(rows[i].pb ? DIR_SEL_B : DIR_SEL_A, rows[i].dir);
         wr(rows[i].pb ? ADDR_PORT_B : ADDR_PORT_A, {2'h3, rows[i].lat});
         ext_a_en = rows[i].pb ? 6'h00 : rows[i].een;
         ext_b_en = rows[i].pb ? rows[i].een : 6'h00;
         ext_a = rows[i].ev;
         ext_b = rows[i].ev;
         idle(3);
         rd(rows[i].pb ? ADDR_PORT_B : ADDR_PORT_A, rows[i].exp);
         chk("oe", {2'h0, ~rows[i].dir & (rows[i].pb ? 6'h3f : 6'h37)}, {2'h0, rows[i].pb ? pin_b_oe : pin_a_oe});
      end
      ext_a_en = 6'h08;
      ext_a = 6'h08;
      alt_fn_a = 6'h21;
      alt_fn_b = 6'h0f;
      idle(3);
      rd(ADDR_PORT_A, 8'h1e);
      rd(ADDR_PORT_B, 8'h20);
      opt(8'hff);
      chk("oe_a", 8'h33, {2'h0, pin_a_oe});
      chk("pullup", 8'h00, {2'h0, pullup_en});
      master_clear_input = 1;
      idle(1);
      chk("pullup", 8'h08, {2'h0, pullup_en});
      opt(8'h9f);
      chk("pullup", {2'h0, SHARED_MASK}, {2'h0, pullup_en});
      opt(8'h5f);
      dir(DIR_SEL_A, 6'h3f);
      ext_a_en = 6'h3f;
      ext_a = 6'h00;
      idle(3);
      rd(ADDR_PORT_A, 8'h00);
      ext_a = 6'h0c;
      idle(3);
      chk("wake", 8'h00, {7'h0, wake_event});
      ext_a = 6'h0d;
      idle(3);
      chk("wake", 8'h01, {7'h0, wake_event});
      opt(8'hdf);
      chk("wake", 8'h00, {7'h0, wake_event});
      wr(ADDR_PORT_A, 8'h2d);
      rst(1);
      chk("flag", 8'h01, {7'h0, wake_change_reset_flag});
      rd(ADDR_STATUS, 8'h80);
      chk("oe_a", 8'h00, {2'h0, pin_a_oe});
      dir(DIR_SEL_A, 6'h00);
      chk("out_a", 8'h21, {2'h0, pin_a_out});
      rst(0);
      chk("flag", 8'h00, {7'h0, wake_change_reset_flag});
      opt(8'hdf);
      alt_fn_a = 6'h00;
      dir(DIR_SEL_A, 6'h01);
      wr(ADDR_PORT_A, 8'h00);
      ext_a_en = 6'h09;
      ext_a = 6'h01;
      idle(3);
      rmw(1, 3'h5);
      dir(DIR_SEL_A, 6'h00);
      chk("out_a", 8'h21, {2'h0, pin_a_out});
      idle(3);
      rmw(0, 3'h0);
      chk("out_a", 8'h20, {2'h0, pin_a_out});
      dir(3'h5, 6'h00);
      chk("oe_b", 8'h00, {2'h0, pin_b_oe});
      rd(5'h04, 8'h00);
      results;
   end
endmodule : tb_top
